// File: rtl/acg_consts.vh
`ifndef ACG_CONSTS_VH
`define ACG_CONSTS_VH

// Register indices; the Avalon byte address is four times the index.
`define ACG_IDX_CTRL 8'h30
`define ACG_IDX_CTS0 8'h31
`define ACG_IDX_CTS1 8'h32
`define ACG_IDX_CTS2 8'h33
`define ACG_IDX_N0 8'h34
`define ACG_IDX_N1 8'h35
`define ACG_IDX_N2C 8'h36
`define ACG_IDX_STATUS 8'h37
`define ACG_NUM_RW 7

// Field positions in the clock control register.
`define ACG_CTRL_FRAME 7
`define ACG_CTRL_MBR_HI 6
`define ACG_CTRL_MBR_LO 5
`define ACG_CTRL_CDIV_HI 4
`define ACG_CTRL_CDIV_LO 3
`define ACG_CTRL_CLEAN_HI 2
`define ACG_CTRL_CLEAN_LO 1
`define ACG_CTRL_MASTER 0

// Field positions in the divisor top and filter register.
`define ACG_N2C_SHIFT_HI 7
`define ACG_N2C_SHIFT_LO 4
`define ACG_N2C_NTOP_HI 3
`define ACG_N2C_NTOP_LO 0

// Field positions in the cleaner status register.
`define ACG_STS_IN_HI 5
`define ACG_STS_IN_LO 3
`define ACG_STS_OUT_HI 2
`define ACG_STS_OUT_LO 0

// Reset values.
`define ACG_REG_RESET 8'h00
`define ACG_STEP_RESET 16'h4000

// Last bit clock count of a word select half frame, for 64 and 32 bit frames.
`define ACG_HALF_FRAME64 5'h1F
`define ACG_HALF_FRAME32 5'h0F

// Input level the cleaner loop steers towards.
`define ACG_IN_TARGET 4'h4

`endif

// File: rtl/acg_clock_cleaner.v
`timescale 1ns/1ps
`include "acg_consts.vh"

module acg_clock_cleaner (
    input wire core_clk,
    input wire reset_n,
    input wire enable,
    input wire src_event,
    input wire ref_tick,
    input wire [1:0] clean_ratio,
    input wire [3:0] loop_filter_shift,
    output reg clean_clk,
    output reg [2:0] cleaner_input_level,
    output reg [2:0] cleaner_output_level
);

    reg [15:0] phase;
    reg [15:0] step;
    wire [16:0] nco_sum = {1'b0, phase} + {1'b0, step};
    wire nco_tick = ref_tick & nco_sum[16];
    wire [3:0] level_err = {1'b0, cleaner_input_level} - `ACG_IN_TARGET;
    // Feedback is scaled down by two to the loop filter shift.
    wire signed [15:0] err_wide = $signed({{4{level_err[3]}}, level_err, 8'h00});
    wire signed [15:0] err_scaled = err_wide >>> loop_filter_shift; // RULE_08
    reg [2:0] ratio_n;
    reg [3:0] out_sum;

    // Output events per cleaned clock toggle.
    always @*
    begin
        case (clean_ratio)
            2'h1: ratio_n = 3'h1;
            2'h2: ratio_n = 3'h2;
            default: ratio_n = 3'h4;
        endcase
        out_sum = {1'b0, cleaner_output_level} + {3'h0, nco_tick};
    end

    // Input FIFO counts source edges not yet matched by an NCO tick.
    // It saturates at seven so a runaway source cannot wrap the level.
    always @(posedge core_clk)
    begin
        if (!reset_n || !enable)
        begin
            cleaner_input_level <= 3'h0;
        end
        else if (src_event && !nco_tick && cleaner_input_level != 3'h7)
        begin
            cleaner_input_level <= cleaner_input_level + 3'h1;
        end
        else if (nco_tick && !src_event && cleaner_input_level != 3'h0)
        begin
            cleaner_input_level <= cleaner_input_level - 3'h1;
        end
    end

    // The NCO runs on the reference; its step follows the input level.
    always @(posedge core_clk)
    begin
        if (!reset_n || !enable)
        begin
            phase <= 16'h0000;
            step <= `ACG_STEP_RESET;
        end
        else
        begin
            if (ref_tick)
            begin
                phase <= nco_sum[15:0];
            end
            if (src_event)
            begin
                step <= step + err_scaled; // RULE_04
            end
        end
    end

    // Output FIFO releases one clean toggle per ratio of NCO ticks.
    always @(posedge core_clk)
    begin
        if (!reset_n || !enable)
        begin
            cleaner_output_level <= 3'h0;
            clean_clk <= 1'b0;
        end
        else if (out_sum >= {1'b0, ratio_n})
        begin
            cleaner_output_level <= out_sum[2:0] - ratio_n; // RULE_04
            clean_clk <= ~clean_clk;
        end
        else
        begin
            cleaner_output_level <= out_sum[2:0];
        end
    end

endmodule

// File: rtl/acg_audio_clock_generator.v
`timescale 1ns/1ps
`include "acg_consts.vh"

// Function
// RULE_01: Frame bit picks 64 or 32 bit clocks.
// RULE_02: Ratio field picks 4, 2, 1, 8 master clocks.
// RULE_03: Divider picks VCO/8, /4, /2 or oscillator.
// RULE_04: Nonzero clean mode cleans clock; ratios 1,2,4.
// RULE_05: Master bit drives bit clock and word select.
// RULE_06: Nonzero 24-bit time stamp regenerates audio clock.
// RULE_07: Nonzero 20-bit divisor joins clock regeneration.
// RULE_08: Loop filter divides feedback by two^shift.
// RULE_09: Status shows input and output FIFO levels.
// RULE_10: Master divides master clock, toggles word select.
module acg_audio_clock_generator (
    input wire core_clk,
    input wire reset_n,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire master_clock_pin,
    input wire link_pll_vco_clock,
    input wire always_on_oscillator,
    input wire bit_clock_in,
    input wire word_select_pin_in,
    output reg bit_clock_out,
    output reg bit_clock_oe_n,
    output reg word_select_pin_out,
    output reg word_select_pin_oe_n,
    output reg audio_clock,
    output reg audio_word_select
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam NUM_PINS = 5;
    localparam PIN_MCLK = 0;
    localparam PIN_BCLK = 1;
    localparam PIN_WS = 2;
    localparam PIN_VCO = 3;
    localparam PIN_AON = 4;

    wire [NUM_PINS-1:0] pin_raw = {always_on_oscillator, link_pll_vco_clock,
                                   word_select_pin_in, bit_clock_in, master_clock_pin};
    reg [NUM_PINS-1:0] pin_meta;
    reg [NUM_PINS-1:0] pin_sync;
    reg [NUM_PINS-1:0] pin_prev;
    wire [NUM_PINS-1:0] pin_rise = pin_sync & ~pin_prev;
    wire [NUM_PINS-1:0] pin_edge = pin_sync ^ pin_prev;

    // Every pin passes three flops; only the second and later are read.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_sync
            always @(posedge core_clk)
            begin
                if (!reset_n)
                begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                    pin_prev[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_prev[gi] <= pin_sync[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register file and Avalon slave.

    reg [7:0] regs [0:`ACG_NUM_RW-1];
    wire [7:0] word_idx = avs_address[9:2];
    wire idx_hit = (word_idx >= `ACG_IDX_CTRL) && (word_idx <= `ACG_IDX_STATUS);
    wire [7:0] idx_off = word_idx - `ACG_IDX_CTRL;
    wire [2:0] reg_sel = idx_off[2:0];
    wire [2:0] cleaner_input_level;
    wire [2:0] cleaner_output_level;
    wire [7:0] status_val;
    reg [7:0] next_readdata;

    assign status_val = {2'h0, cleaner_input_level, cleaner_output_level}; // RULE_09

    // Read multiplexer; unmapped and reserved bits read as zero.
    always @*
    begin
        next_readdata = 8'h00;
        if (idx_hit)
        begin
            if (reg_sel == 3'h7)
            begin
                next_readdata = status_val; // RULE_09
            end
            else
            begin
                next_readdata = regs[reg_sel];
            end
        end
    end

    // Each access waits one cycle: waitrequest drops in the cycle after the
    // request shows up, and the access completes at that edge. Registering
    // readdata that way keeps the read path off the bus timing.
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? {24'h00_0000, next_readdata} : avs_readdata;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Writes land at the completing edge; the status word is read only.
    genvar ri;
    generate
        for (ri = 0; ri < `ACG_NUM_RW; ri = ri + 1)
        begin : g_regs
            always @(posedge core_clk)
            begin
                if (!reset_n)
                begin
                    regs[ri] <= `ACG_REG_RESET;
                end
                else if (avs_write && !avs_waitrequest && idx_hit && avs_byteenable[0]
                         && reg_sel == ri)
                begin
                    regs[ri] <= avs_writedata[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control fields.

    wire [7:0] ctrl = regs[0];
    wire frame32 = ctrl[`ACG_CTRL_FRAME];
    wire [1:0] mbr_sel = ctrl[`ACG_CTRL_MBR_HI:`ACG_CTRL_MBR_LO];
    wire [1:0] cdiv_sel = ctrl[`ACG_CTRL_CDIV_HI:`ACG_CTRL_CDIV_LO];
    wire [1:0] clean_mode = ctrl[`ACG_CTRL_CLEAN_HI:`ACG_CTRL_CLEAN_LO];
    wire master = ctrl[`ACG_CTRL_MASTER];
    wire [23:0] time_stamp = {regs[3], regs[2], regs[1]}; // RULE_06
    wire [19:0] regen_divisor = {regs[6][`ACG_N2C_NTOP_HI:`ACG_N2C_NTOP_LO],
                                 regs[5], regs[4]}; // RULE_07
    wire [3:0] loop_filter_shift = regs[6][`ACG_N2C_SHIFT_HI:`ACG_N2C_SHIFT_LO];

    ////////////////////////////////////////////////////////////////////////
    // Master mode bit clock and word select generation.

    reg [3:0] mclk_edges_per_half;
    reg [3:0] mclk_cnt;
    reg [4:0] ws_cnt;
    wire [4:0] ws_half_last = frame32 ? `ACG_HALF_FRAME32 : `ACG_HALF_FRAME64; // RULE_01

    // A bit clock of ratio R master periods toggles every R master edges,
    // so ratio 1 simply follows the master clock edge for edge.
    always @*
    begin
        case (mbr_sel)
            2'h0: mclk_edges_per_half = 4'h4; // RULE_02
            2'h1: mclk_edges_per_half = 4'h2;
            2'h2: mclk_edges_per_half = 4'h1;
            default: mclk_edges_per_half = 4'h8;
        endcase
    end

    // Word select flips on the bit clock falling edge after each half frame.
    always @(posedge core_clk)
    begin
        if (!reset_n || !master)
        begin
            mclk_cnt <= 4'h0;
            ws_cnt <= 5'h00;
            bit_clock_out <= 1'b0;
            word_select_pin_out <= 1'b0;
        end
        else if (pin_edge[PIN_MCLK])
        begin
            if (mclk_cnt + 4'h1 >= mclk_edges_per_half)
            begin
                mclk_cnt <= 4'h0;
                bit_clock_out <= ~bit_clock_out; // RULE_10
                if (bit_clock_out)
                begin
                    if (ws_cnt == ws_half_last)
                    begin
                        ws_cnt <= 5'h00;
                        word_select_pin_out <= ~word_select_pin_out; // RULE_10
                    end
                    else
                    begin
                        ws_cnt <= ws_cnt + 5'h01;
                    end
                end
            end
            else
            begin
                mclk_cnt <= mclk_cnt + 4'h1;
            end
        end
    end

    // Pin direction: enables are low while the pins are driven.
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            bit_clock_oe_n <= 1'b1;
            word_select_pin_oe_n <= 1'b1;
        end
        else
        begin
            bit_clock_oe_n <= ~master; // RULE_05
            word_select_pin_oe_n <= ~master; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Audio clock regeneration from the link PLL VCO.

    wire regen_on = (time_stamp != 24'h00_0000) && (regen_divisor != 20'h0_0000);
    reg [23:0] regen_acc;
    reg regen_clk;
    wire [24:0] acc_sum = {1'b0, regen_acc} + {5'h00, regen_divisor};
    wire [24:0] acc_wrap = acc_sum - {1'b0, time_stamp};

    // Fractional accumulator: each VCO edge adds the divisor, and every
    // wrap past the time stamp toggles the regenerated clock. A divisor
    // above the time stamp saturates at one toggle per VCO edge.
    always @(posedge core_clk)
    begin
        if (!reset_n || !regen_on)
        begin
            regen_acc <= 24'h00_0000;
            regen_clk <= 1'b0;
        end
        else if (pin_rise[PIN_VCO])
        begin
            if (acc_sum >= {1'b0, time_stamp})
            begin
                regen_acc <= acc_wrap[23:0]; // RULE_06
                regen_clk <= ~regen_clk; // RULE_07
            end
            else
            begin
                regen_acc <= acc_sum[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cleaner reference selection.

    reg [2:0] vco_div_cnt;
    reg ref_tick;

    // Free running VCO edge counter for the divided references.
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            vco_div_cnt <= 3'h0;
        end
        else if (pin_rise[PIN_VCO])
        begin
            vco_div_cnt <= vco_div_cnt + 3'h1;
        end
    end

    // One reference tick per divided VCO period or per oscillator edge.
    always @*
    begin
        case (cdiv_sel)
            2'h0: ref_tick = pin_rise[PIN_VCO] && (vco_div_cnt == 3'h7); // RULE_03
            2'h1: ref_tick = pin_rise[PIN_VCO] && (vco_div_cnt[1:0] == 2'h3);
            2'h2: ref_tick = pin_rise[PIN_VCO] && vco_div_cnt[0];
            default: ref_tick = pin_rise[PIN_AON];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source, cleaner and audio clock outputs.

    wire src_clk = regen_on ? regen_clk : (master ? bit_clock_out : pin_sync[PIN_BCLK]);
    reg src_prev;
    wire clean_clk;

    // Edge detect on the chosen source feeds the cleaner input FIFO.
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            src_prev <= 1'b0;
        end
        else
        begin
            src_prev <= src_clk;
        end
    end

    acg_clock_cleaner u_cleaner (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .enable(clean_mode != 2'h0),
        .src_event(src_clk ^ src_prev),
        .ref_tick(ref_tick),
        .clean_ratio(clean_mode),
        .loop_filter_shift(loop_filter_shift),
        .clean_clk(clean_clk),
        .cleaner_input_level(cleaner_input_level),
        .cleaner_output_level(cleaner_output_level)
    );

    // Clean mode zero bypasses the cleaner and passes the source through.
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            audio_clock <= 1'b0;
            audio_word_select <= 1'b0;
        end
        else
        begin
            audio_clock <= (clean_mode == 2'h0) ? src_clk : clean_clk; // RULE_04
            audio_word_select <= master ? word_select_pin_out : pin_sync[PIN_WS];
        end
    end

endmodule

// File: dv/acg_checker_properties.sv
`timescale 1ns/1ps
module acg_checker (
    input wire core_clk,
    input wire reset_n,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire bit_clock_out,
    input wire bit_clock_oe_n,
    input wire word_select_pin_out,
    input wire word_select_pin_oe_n
);
    // Every check runs on the core clock and rests while reset is held.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    wire req = avs_read || avs_write;
    ////////////////////////////////////////
    // The bus answers after exactly one wait cycle and never answers unasked.
    wait_single_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!req |=> avs_waitrequest)
        else $error("waitrequest low without request");
    // Read data may only move when a read is being answered.
    readdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("read data changed without read");
    status_pad_a: assert property (avs_read && avs_waitrequest && avs_address[9:2] == 8'h37
        |=> avs_readdata[31:6] == 26'h0)
        else $error("status read has nonzero upper bits");
    ////////////////////////////////////////
    // Both pins turn round together; a pin that is not driven shows a quiet value.
    oe_pair_a: assert property (bit_clock_oe_n == word_select_pin_oe_n)
        else $error("pin enables differ");
    slave_quiet_a: assert property (bit_clock_oe_n && $past(bit_clock_oe_n)
        |-> !bit_clock_out && !word_select_pin_out)
        else $error("drive value moves while pins are inputs");
    // The test master clock has 8 core cycles a period, so no half bit clock is shorter than 4.
    // Leaving master mode may drop the drive value at once, so released pins are exempt.
    bclk_hold_a: assert property ($changed(bit_clock_out)
        |=> ($stable(bit_clock_out) || bit_clock_oe_n)[*3])
        else $error("bit clock half period too short");
    ws_hold_a: assert property ($changed(word_select_pin_out) && !word_select_pin_oe_n
        |=> ($stable(word_select_pin_out) || word_select_pin_oe_n)[*8])
        else $error("word select half frame too short");
    ws_on_fall_a: assert property ($changed(word_select_pin_out) && !word_select_pin_oe_n
        |-> !bit_clock_out)
        else $error("word select moved while bit clock high");
    cover property (req && !avs_waitrequest);
    cover property ($fell(bit_clock_oe_n));
    cover property (!word_select_pin_oe_n && $changed(word_select_pin_out));
endmodule

bind acg_audio_clock_generator acg_checker acg_checker_i (.core_clk(core_clk),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bit_clock_out(bit_clock_out), .bit_clock_oe_n(bit_clock_oe_n),
    .word_select_pin_out(word_select_pin_out), .word_select_pin_oe_n(word_select_pin_oe_n));

// File: dv/acg_audio_peer.sv
`timescale 1ns/1ps
module acg_audio_peer (
    input wire slave_run,
    input wire bit_clock_out,
    input wire bit_clock_oe_n,
    input wire word_select_pin_out,
    input wire word_select_pin_oe_n,
    output reg master_clock_pin,
    output reg link_pll_vco_clock,
    output reg always_on_oscillator,
    output wire bit_clock_line,
    output wire word_select_line
);
    reg own_bclk;
    reg own_ws;
    integer falls;
    // Free sources sit off the core rising edges so sampling never races them.
    initial
    begin
        {master_clock_pin, link_pll_vco_clock, always_on_oscillator} = 3'h0;
        {own_bclk, own_ws} = 2'h0;
        falls = 0;
        #3;
        forever #40 master_clock_pin = ~master_clock_pin;
    end
    always #30 link_pll_vco_clock = ~link_pll_vco_clock;
    always #44 always_on_oscillator = ~always_on_oscillator;
    // As clock owner in slave mode the peer runs a 64 bit frame, and stands still between runs.
    always #80
    begin
        if (slave_run)
        begin
            own_bclk = ~own_bclk;
            if (!own_bclk)
                falls = falls + 1;
            if (falls == 32)
            begin
                falls = 0;
                own_ws = ~own_ws;
            end
        end
    end
    // The line carries whichever party drives it; the device drives with its enable low.
    assign bit_clock_line = bit_clock_oe_n ? own_bclk : bit_clock_out;
    assign word_select_line = word_select_pin_oe_n ? own_ws : word_select_pin_out;
endmodule

// File: dv/acg_audio_clock_generator_tb_top.sv
`timescale 1ns/1ps
module acg_audio_clock_generator_tb_top;
    reg core_clk, reset_n, avs_read, avs_write, slave_run;
    reg [9:0] avs_address;
    reg [31:0] avs_writedata;
    reg [3:0] avs_byteenable;
    reg [7:0] rd;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, mclk, vco, osc, bclk_line, ws_line, bclk, bclk_oe_n;
    wire ws, ws_oe_n, audio_clock, audio_ws;
    integer n_errors = 0;
    integer checked = 0;
    integer c;
    acg_audio_clock_generator acg_audio_clock_generator_i (.core_clk(core_clk),
        .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .master_clock_pin(mclk), .link_pll_vco_clock(vco), .always_on_oscillator(osc),
        .bit_clock_in(bclk_line), .word_select_pin_in(ws_line), .bit_clock_out(bclk),
        .bit_clock_oe_n(bclk_oe_n), .word_select_pin_out(ws), .word_select_pin_oe_n(ws_oe_n),
        .audio_clock(audio_clock), .audio_word_select(audio_ws));
    acg_audio_peer acg_audio_peer_i (.slave_run(slave_run), .bit_clock_out(bclk),
        .bit_clock_oe_n(bclk_oe_n), .word_select_pin_out(ws), .word_select_pin_oe_n(ws_oe_n),
        .master_clock_pin(mclk), .link_pll_vco_clock(vco), .always_on_oscillator(osc),
        .bit_clock_line(bclk_line), .word_select_line(ws_line));
    ////////////////////////////////////////
    // Free clock and shared helpers.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task compare(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One bus cycle; the request is held until waitrequest is seen low at a rising edge.
    task bus(input wr, input [7:0] idx, input [7:0] d, input [3:0] be);
        integer n;
    begin
        n = 0;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            n = n + 1;
            @(posedge core_clk);
        end
        compare(n < 20, 1);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    end
    endtask
    // Counts audio clock changes; t_regen runs a settle span first before each count that expects no toggles.
    task count_toggles(input integer cycles);
        integer i;
        reg last;
    begin
        c = 0;
        last = audio_clock;
        for (i = 0; i < cycles; i = i + 1)
        begin
            @(posedge core_clk);
            c = c + (audio_clock !== last);
            last = audio_clock;
        end
    end
    endtask
    ////////////////////////////////////////
    // Reset values, read back, refused writes and an unmapped place.
    task t_registers;
        integer i;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(0, 8'h30 + i, 8'h00, 4'hF);
            compare(rd, 8'h00);
        end
        for (i = 0; i < 7; i = i + 1)
            bus(1, 8'h30 + i, 8'h98 + i, 4'hF);
        bus(1, 8'h37, 8'hFF, 4'hF);
        bus(1, 8'h31, 8'h00, 4'h0);
        bus(1, 8'h40, 8'h55, 4'hF);
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(0, 8'h30 + i, 8'h00, 4'hF);
            compare(rd, i == 7 ? 8'h00 : 8'h98 + i);
        end
        bus(0, 8'h40, 8'h00, 4'hF);
        compare(rd, 8'h00);
        for (i = 0; i < 7; i = i + 1)
            bus(1, 8'h30 + i, 8'h00, 4'hF);
    end
    endtask
    // Every ratio with both frame lengths: bit clock period and half frame length.
    task t_master;
        integer i;
        time t0;
        reg w;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(1, 8'h30, {i[2], i[1:0], 5'h01}, 4'hF);
            @(posedge bclk);
            compare({bclk_oe_n, ws_oe_n}, 0);
            @(posedge bclk);
            t0 = $time;
            @(posedge bclk);
            compare(($time - t0) / 10, i[1:0] == 3 ? 64 : 32 >> i[1:0]);
            @(ws);
            w = ws;
            c = 0;
            while (ws === w && c < 100)
            begin
                @(posedge bclk or ws);
                c = c + (bclk === 1'b1 && ws === w);
            end
            compare(c, i[2] ? 16 : 32);
        end
        bus(1, 8'h30, 8'h00, 4'hF);
        repeat (2) @(posedge core_clk);
        compare({bclk_oe_n, ws_oe_n}, 3);
    end
    endtask
    // Slave mode with cleaning off: pins are followed straight through.
    task t_slave;
    begin
        slave_run <= 1'b1;
        repeat (3)
        begin
            @(ws_line);
            repeat (6) @(posedge core_clk);
            compare(audio_ws, ws_line);
            @(posedge bclk_line);
            repeat (6) @(posedge core_clk);
            compare(audio_clock, 1);
        end
    end
    endtask
    // Each reference choice with a cleaning ratio, then bypass which clears the levels.
    // The source outruns every reference, so the input level sits at six or seven.
    task t_cleaner;
        integer i;
    begin
        bus(1, 8'h36, 8'h40, 4'hF);
        for (i = 0; i < 4; i = i + 1)
        begin
            bus(1, 8'h30, {3'h0, i[1:0], i == 0 ? 2'h3 : i[1:0], 1'b0}, 4'hF);
            count_toggles(6000);
            compare(c > 0, 1);
            bus(0, 8'h37, 8'h00, 4'hF);
            compare(rd & 8'hF0, 8'h30);
        end
        bus(1, 8'h30, 8'h00, 4'hF);
        bus(0, 8'h37, 8'h00, 4'hF);
        compare(rd, 8'h00);
    end
    endtask
    // Regeneration needs both values; the filter nibble must not count as divisor.
    task t_regen;
    begin
        slave_run <= 1'b0;
        bus(1, 8'h33, 8'h01, 4'hF);
        bus(1, 8'h36, 8'hF0, 4'hF);
        count_toggles(200);
        count_toggles(1000);
        compare(c, 0);
        bus(1, 8'h36, 8'hF1, 4'hF);
        count_toggles(1000);
        compare(c > 0, 1);
        bus(1, 8'h33, 8'h00, 4'hF);
        count_toggles(200);
        count_toggles(1000);
        compare(c, 0);
    end
    endtask
    ////////////////////////////////////////
    task end_of_test;
    begin
        $display("Comparisons %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // The tests take about 41k cycles; the watchdog allows 80k.
    initial
    begin
        #800000;
        n_errors = n_errors + 1;
        end_of_test;
    end
    // Main sequence.
    initial
    begin
        {reset_n, avs_read, avs_write, slave_run} = 4'h0;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_registers;
        t_master;
        t_slave;
        t_cleaner;
        t_regen;
        end_of_test;
    end
endmodule
